// ==== hw/cache_wb_pkg.sv ====
`default_nettype none
package cache_wb_pkg;

	// Bus widths; host addresses carry A[27:2]
	localparam int ADDR_W        = 26;
	localparam int DATA_W        = 32;
	localparam int BE_W          = 4;

	// Cache geometry
	localparam int WAYS          = 2;
	localparam int MAX_LINES     = 4096;
	localparam int GROUPS        = 256;
	localparam int TAG_W         = 14;
	localparam int LINE_DWORDS   = 4;
	localparam int GROUP_LINES   = 16;

	// Cache size select codes
	localparam logic [1:0] SIZE_32K  = 2'h0;
	localparam logic [1:0] SIZE_64K  = 2'h1;
	localparam logic [1:0] SIZE_128K = 2'h2;

	// Posted write queue and read return buffer
	localparam int WQ_DEPTH      = 4;
	localparam int RD_FIFO_DEPTH = 16;

	// Reset values and the read request byte enable
	localparam logic [2:0]  WQ_COUNT_RESET = 3'h0;
	localparam logic [1:0]  WQ_PTR_RESET   = 2'h0;
	localparam logic [3:0]  BYTE_SEL_IDLE  = 4'hF;
	localparam logic [3:0]  BYTE_EN_ALL    = 4'hF;

	typedef struct packed {
		logic                write;
		logic                burst;
		logic [ADDR_W-1:0]   addr;
		logic [BE_W-1:0]     byte_en;
		logic [DATA_W-1:0]   data;
	} mem_req_t;

	typedef struct packed {
		logic                write;
		logic                non_cache;
		logic [ADDR_W-1:0]   addr;
		logic [BE_W-1:0]     byte_en;
		logic [DATA_W-1:0]   data;
	} host_cyc_t;

	typedef enum logic [2:0] {
		ST_IDLE       = 3'b000,
		ST_LOOKUP     = 3'b001,
		ST_FILL_REQ   = 3'b010,
		ST_FILL       = 3'b011,
		ST_DONE       = 3'b100,
		ST_SINGLE_REQ = 3'b101,
		ST_SINGLE     = 3'b110
	} ctl_state_t;

endpackage : cache_wb_pkg
`default_nettype wire

// ==== hw/cache_and_write_buffer_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none

module stream_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [PW-1:0]    wptr_reg;
	logic [PW-1:0]    rptr_reg;
	logic [CW-1:0]    count_reg;
	logic [CW-1:0]    count_next;
	logic             push;
	logic             pop;

	assign push       = in_valid && in_ready;
	assign pop        = out_valid && out_ready;
	assign count_next = count_reg + CW'(push) - CW'(pop);
	assign out_valid  = (count_reg != '0);
	assign out_data   = mem[rptr_reg];

	always_ff @(posedge ref_clk) begin
		if (push)
			mem[wptr_reg] <= in_data;
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			wptr_reg  <= '0;
			rptr_reg  <= '0;
			count_reg <= '0;
			in_ready  <= 1'b0;
		end else begin
			wptr_reg  <= push ? PW'(wptr_reg + 1'b1) : wptr_reg;
			rptr_reg  <= pop ? PW'(rptr_reg + 1'b1) : rptr_reg;
			count_reg <= count_next;
			in_ready  <= (count_next != FULL_COUNT);
		end
	end
endmodule : stream_fifo

module cache_and_write_buffer_ctrl
	import cache_wb_pkg::*;
(
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rstn,
	// Configuration
	input  wire logic [1:0]        cfg_cache_size,
	input  wire logic              cfg_noncache_region,
	// Host local bus
	input  wire logic              host_addr_strobe_n,
	input  wire logic              host_non_cache_n,
	input  wire logic              host_write,
	input  wire logic [ADDR_W-1:0] host_addr,
	input  wire logic [BE_W-1:0]   host_byte_en_n,
	input  wire logic [DATA_W-1:0] host_wdata,
	output logic                   host_ready_n,
	output logic [DATA_W-1:0]      host_rdata,
	// Cache data SRAM
	output logic                   way0_output_enable_n,
	output logic                   way1_output_enable_n,
	output logic                   way0_write_strobe_n,
	output logic                   way1_write_strobe_n,
	output logic [BE_W-1:0]        cache_byte_select_n,
	output logic                   cache_low_addr1,
	output logic                   cache_low_addr0,
	output logic                   cache_addr_latch_en,
	output logic [DATA_W-1:0]      cache_wdata,
	// DRAM sequencer
	output logic                   dram_req_valid,
	output mem_req_t               dram_req,
	input  wire logic              dram_req_ready,
	input  wire logic              dram_rd_valid,
	input  wire logic [DATA_W-1:0] dram_rd_data,
	output logic                   dram_rd_ready
);
	ctl_state_t           state_reg;
	host_cyc_t            cyc_reg;
	host_cyc_t            hold_reg;
	logic                 hold_valid_reg;
	logic [TAG_W-1:0]     tag_mem [0:WAYS-1][0:GROUPS-1];
	logic [WAYS-1:0][MAX_LINES-1:0] valid_reg;
	logic [MAX_LINES-1:0] lru_reg;
	logic                 fill_way_reg;
	logic [1:0]           fill_cnt_reg;
	logic [2:0]           fill_writes_reg;
	logic [ADDR_W-1:0]    wq_addr [0:WQ_DEPTH-1];
	logic [DATA_W-1:0]    wq_data [0:WQ_DEPTH-1];
	logic [BE_W-1:0]      wq_be   [0:WQ_DEPTH-1];
	logic [WQ_DEPTH-1:0]  wq_valid_reg;
	logic [1:0]           wq_head_reg;
	logic [1:0]           wq_tail_reg;
	logic [2:0]           wq_count_reg;

	function automatic logic [11:0] line_of(input logic [ADDR_W-1:0] a, input logic [1:0] sz);
		case (sz)
			SIZE_32K: line_of = {2'h0, a[11:2]};
			SIZE_64K: line_of = {1'h0, a[12:2]};
			default:  line_of = a[13:2];
		endcase
	endfunction : line_of

	function automatic logic [7:0] group_of(input logic [ADDR_W-1:0] a, input logic [1:0] sz);
		case (sz)
			SIZE_32K: group_of = a[11:4];
			SIZE_64K: group_of = a[12:5];
			default:  group_of = a[13:6];
		endcase
	endfunction : group_of

	function automatic logic [TAG_W-1:0] tag_of(input logic [ADDR_W-1:0] a, input logic [1:0] sz);
		case (sz)
			SIZE_32K: tag_of = a[25:12];
			SIZE_64K: tag_of = {a[25:13], 1'h0};
			default:  tag_of = {a[25:14], 2'h0};
		endcase
	endfunction : tag_of

	function automatic logic [11:0] group_line(input logic [7:0] g, input logic [1:0] sz,
		input logic [3:0] j);
		case (sz)
			SIZE_32K: group_line = {2'h0, g, j[1:0]};
			SIZE_64K: group_line = {1'h0, g, j[2:0]};
			default:  group_line = {g, j};
		endcase
	endfunction : group_line

	// Lookup on the captured cycle
	logic [11:0]      lk_line;
	logic [7:0]       lk_group;
	logic [TAG_W-1:0] lk_tag;
	logic [WAYS-1:0]  way_hit;
	logic             any_hit;
	logic             hit_way;
	logic             fill_way;
	logic             in_lookup;
	logic             hold_accept;
	logic             lk_wr_go;
	logic             lk_rd_go;
	logic             rd_hit_c;
	logic             fill_go;
	logic             single_go;
	logic             fifo_valid;
	logic             fifo_pop;
	logic [DATA_W-1:0] fifo_data;
	logic [ADDR_W-1:0] rd_dword_addr;
	logic [DATA_W-1:0] rd_merged;

	assign lk_line  = line_of(cyc_reg.addr, cfg_cache_size);
	assign lk_group = group_of(cyc_reg.addr, cfg_cache_size);
	assign lk_tag   = tag_of(cyc_reg.addr, cfg_cache_size);

	for (genvar w = 0; w < WAYS; w++) begin : g_way
		assign way_hit[w] = valid_reg[w][lk_line] && (tag_mem[w][lk_group] == lk_tag);
	end

	assign any_hit   = |way_hit;
	assign hit_way   = way_hit[1];
	assign fill_way  = !valid_reg[0][lk_line] ? 1'b0 :
		(!valid_reg[1][lk_line] ? 1'b1 : lru_reg[lk_line]);
	assign in_lookup = (state_reg == ST_LOOKUP);
	assign lk_wr_go  = in_lookup && cyc_reg.write && hold_accept;
	assign lk_rd_go  = in_lookup && !cyc_reg.write && !hold_valid_reg;
	assign rd_hit_c  = lk_rd_go && any_hit && !cyc_reg.non_cache;
	assign fill_go   = lk_rd_go && !any_hit && !cyc_reg.non_cache;
	assign single_go = lk_rd_go && cyc_reg.non_cache;
	assign fifo_pop  = fifo_valid && ((state_reg == ST_FILL) || (state_reg == ST_SINGLE));
	assign rd_dword_addr = (state_reg == ST_FILL) ?
		{cyc_reg.addr[25:2], cyc_reg.addr[1:0] ^ ~fill_cnt_reg} : cyc_reg.addr;

	// Write queue matching and read forwarding
	logic [WQ_DEPTH-1:0] hold_match;
	logic [WQ_DEPTH-1:0] rd_match;
	logic                slot_free;
	logic                rd_want;
	logic                rd_busy;
	logic                rd_load;
	logic                wq_load;
	logic                hold_move;
	logic                wq_push;

	for (genvar i = 0; i < WQ_DEPTH; i++) begin : g_wq
		assign hold_match[i] = wq_valid_reg[i] && (wq_addr[i] == hold_reg.addr) &&
			!(wq_load && (wq_head_reg == 2'(i)));
		assign rd_match[i]   = wq_valid_reg[i] && (wq_addr[i] == rd_dword_addr);
	end

	always_comb begin
		rd_merged = fifo_data;
		for (int i = 0; i < WQ_DEPTH; i++) begin
			for (int b = 0; b < BE_W; b++) begin
				if (rd_match[i] && wq_be[i][b])
					rd_merged[b*8 +: 8] = wq_data[i][b*8 +: 8];
			end
		end
	end

	assign slot_free   = !dram_req_valid || dram_req_ready;
	assign rd_want     = (state_reg == ST_FILL_REQ) || (state_reg == ST_SINGLE_REQ);
	assign rd_busy     = rd_want || (state_reg == ST_FILL) || (state_reg == ST_SINGLE);
	assign rd_load     = slot_free && rd_want;
	assign wq_load     = slot_free && !rd_busy && (wq_count_reg != WQ_COUNT_RESET);
	assign hold_move   = hold_valid_reg && ((|hold_match) || (wq_count_reg < 3'(WQ_DEPTH)));
	assign wq_push     = hold_move && !(|hold_match);
	assign hold_accept = !hold_valid_reg || hold_move;

	stream_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (RD_FIFO_DEPTH)
	) u_rd_fifo (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.in_valid  (dram_rd_valid),
		.in_data   (dram_rd_data),
		.in_ready  (dram_rd_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_data),
		.out_ready (fifo_pop)
	);

	// Cycle control
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE:       if (!host_addr_strobe_n) state_reg <= ST_LOOKUP;
				ST_LOOKUP: begin
					if (lk_wr_go || rd_hit_c)
						state_reg <= ST_IDLE;
					else if (fill_go)
						state_reg <= ST_FILL_REQ;
					else if (single_go)
						state_reg <= ST_SINGLE_REQ;
				end
				ST_FILL_REQ:   if (rd_load) state_reg <= ST_FILL;
				ST_FILL:       if (fifo_pop && (fill_cnt_reg == 2'h3)) state_reg <= ST_DONE;
				ST_DONE:       state_reg <= ST_IDLE;
				ST_SINGLE_REQ: if (rd_load) state_reg <= ST_SINGLE;
				ST_SINGLE:     if (fifo_pop) state_reg <= ST_IDLE;
				default:       state_reg <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn)
			cyc_reg <= '0;
		else if ((state_reg == ST_IDLE) && !host_addr_strobe_n)
			cyc_reg <= '{write: host_write, non_cache: !host_non_cache_n || cfg_noncache_region,
				addr: host_addr, byte_en: ~host_byte_en_n, data: host_wdata};
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			fill_way_reg    <= 1'b0;
			fill_cnt_reg    <= 2'h0;
			fill_writes_reg <= 3'h0;
		end else if (fill_go) begin
			fill_way_reg    <= fill_way;
			fill_cnt_reg    <= 2'h0;
			fill_writes_reg <= 3'h0;
		end else if (fifo_pop && (state_reg == ST_FILL)) begin
			fill_cnt_reg    <= 2'(fill_cnt_reg + 1'b1);
			fill_writes_reg <= 3'(fill_writes_reg + 1'b1);
		end
	end

	// Tag store
	always_ff @(posedge ref_clk) begin
		if (fill_go)
			tag_mem[fill_way][lk_group] <= lk_tag;
	end

	// Valid and LRU state
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			valid_reg <= '0;
			lru_reg   <= '0;
		end else begin
			if (fill_go) begin
				valid_reg[fill_way][lk_line] <= 1'b0;
				if (tag_mem[fill_way][lk_group] != lk_tag) begin
					for (int j = 0; j < GROUP_LINES; j++)
						valid_reg[fill_way][group_line(lk_group, cfg_cache_size, 4'(j))] <= 1'b0;
				end
			end
			if (state_reg == ST_DONE) begin
				valid_reg[fill_way_reg][lk_line] <= 1'b1;
				lru_reg[lk_line] <= !fill_way_reg;
			end
			if (rd_hit_c || (lk_wr_go && any_hit && !cyc_reg.non_cache))
				lru_reg[lk_line] <= !hit_way;
			if ((single_go || lk_wr_go) && any_hit && cyc_reg.non_cache)
				valid_reg[hit_way][lk_line] <= 1'b0;
		end
	end

	// Host termination and read data
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			host_ready_n <= 1'b1;
			host_rdata   <= '0;
		end else begin
			host_ready_n <= !(lk_wr_go || rd_hit_c || (state_reg == ST_DONE) ||
				(fifo_pop && (state_reg == ST_SINGLE)));
			if (fifo_pop && ((state_reg == ST_SINGLE) || (fill_cnt_reg == 2'h3)))
				host_rdata <= rd_merged;
		end
	end

	// Cache SRAM control
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			way0_output_enable_n <= 1'b1;
			way1_output_enable_n <= 1'b1;
			way0_write_strobe_n  <= 1'b1;
			way1_write_strobe_n  <= 1'b1;
			cache_byte_select_n  <= BYTE_SEL_IDLE;
			cache_low_addr1      <= 1'b0;
			cache_low_addr0      <= 1'b0;
			cache_addr_latch_en  <= 1'b0;
			cache_wdata          <= '0;
		end else begin
			way0_output_enable_n <= !(rd_hit_c && !hit_way);
			way1_output_enable_n <= !(rd_hit_c && hit_way);
			way0_write_strobe_n  <= 1'b1;
			way1_write_strobe_n  <= 1'b1;
			cache_byte_select_n  <= BYTE_SEL_IDLE;
			cache_addr_latch_en  <= !((state_reg == ST_IDLE) && host_addr_strobe_n);
			if (rd_hit_c) begin
				cache_byte_select_n <= '0;
				{cache_low_addr1, cache_low_addr0} <= cyc_reg.addr[1:0];
			end else if (lk_wr_go && any_hit && !cyc_reg.non_cache) begin
				way0_write_strobe_n <= hit_way;
				way1_write_strobe_n <= !hit_way;
				cache_byte_select_n <= ~cyc_reg.byte_en;
				{cache_low_addr1, cache_low_addr0} <= cyc_reg.addr[1:0];
				cache_wdata         <= cyc_reg.data;
			end else if (fifo_pop && (state_reg == ST_FILL)) begin
				way0_write_strobe_n <= fill_way_reg;
				way1_write_strobe_n <= !fill_way_reg;
				cache_byte_select_n <= '0;
				{cache_low_addr1, cache_low_addr0} <= rd_dword_addr[1:0];
				cache_wdata         <= rd_merged;
			end
		end
	end

	// Write hold stage
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			hold_valid_reg <= 1'b0;
			hold_reg       <= '0;
		end else if (lk_wr_go) begin
			hold_valid_reg <= 1'b1;
			hold_reg       <= cyc_reg;
		end else if (hold_move) begin
			hold_valid_reg <= 1'b0;
		end
	end

	// Posted write queue
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			wq_valid_reg <= '0;
			wq_head_reg  <= WQ_PTR_RESET;
			wq_tail_reg  <= WQ_PTR_RESET;
			wq_count_reg <= WQ_COUNT_RESET;
		end else begin
			for (int i = 0; i < WQ_DEPTH; i++) begin
				if (hold_move && hold_match[i]) begin
					for (int b = 0; b < BE_W; b++) begin
						if (hold_reg.byte_en[b])
							wq_data[i][b*8 +: 8] <= hold_reg.data[b*8 +: 8];
					end
					wq_be[i] <= wq_be[i] | hold_reg.byte_en;
				end
			end
			if (wq_load)
				wq_valid_reg[wq_head_reg] <= 1'b0;
			if (wq_push) begin
				wq_valid_reg[wq_tail_reg] <= 1'b1;
				wq_addr[wq_tail_reg]      <= hold_reg.addr;
				wq_data[wq_tail_reg]      <= hold_reg.data;
				wq_be[wq_tail_reg]        <= hold_reg.byte_en;
			end
			wq_head_reg  <= wq_load ? 2'(wq_head_reg + 1'b1) : wq_head_reg;
			wq_tail_reg  <= wq_push ? 2'(wq_tail_reg + 1'b1) : wq_tail_reg;
			wq_count_reg <= 3'(wq_count_reg + 3'(wq_push) - 3'(wq_load));
		end
	end

	// DRAM sequencer request port
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			dram_req_valid <= 1'b0;
			dram_req       <= '0;
		end else if (rd_load) begin
			dram_req_valid <= 1'b1;
			dram_req.write <= 1'b0;
			dram_req.burst <= (state_reg == ST_FILL_REQ);
			dram_req.addr  <= (state_reg == ST_FILL_REQ) ?
				{cyc_reg.addr[25:2], cyc_reg.addr[1:0] ^ 2'h3} : cyc_reg.addr;
			dram_req.byte_en <= BYTE_EN_ALL;
			dram_req.data  <= '0;
		end else if (wq_load) begin
			dram_req_valid <= 1'b1;
			dram_req       <= '{write: 1'b1, burst: 1'b0, addr: wq_addr[wq_head_reg],
				byte_en: wq_be[wq_head_reg], data: wq_data[wq_head_reg]};
		end else if (dram_req_ready) begin
			dram_req_valid <= 1'b0;
		end
	end

	sequence s_hit_answer;
		!host_ready_n && (cache_byte_select_n == 4'h0) && cache_addr_latch_en;
	endsequence

	sequence s_fill_end;
		(fill_writes_reg == 3'h4) ##1 !host_ready_n;
	endsequence

	property p_hit_oe_with_ready;
		@(posedge ref_clk) disable iff (!rstn)
		(!way0_output_enable_n || !way1_output_enable_n) |-> s_hit_answer;
	endproperty
	a_hit_oe_with_ready: assert property (p_hit_oe_with_ready) else $error("hit oe without ready");

	property p_one_way_hit;
		@(posedge ref_clk) disable iff (!rstn)
		!(way_hit[0] && way_hit[1]);
	endproperty
	a_one_way_hit: assert property (p_one_way_hit) else $error("hit in both ways");

	property p_read_hit_zero_wait;
		@(posedge ref_clk) disable iff (!rstn)
		rd_hit_c |=> !host_ready_n ##1 (host_ready_n && !dram_req_valid || dram_req.write);
	endproperty
	a_read_hit_zero_wait: assert property (p_read_hit_zero_wait) else $error("read hit slow");

	property p_fill_end;
		@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_DONE) |-> s_fill_end;
	endproperty
	a_fill_end: assert property (p_fill_end) else $error("ready before four fills");

	property p_fill_last_dword;
		@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_DONE) |-> ({cache_low_addr1, cache_low_addr0} == cyc_reg.addr[1:0]);
	endproperty
	a_fill_last_dword: assert property (p_fill_last_dword) else $error("last fill not requested");

	property p_write_zero_wait;
		@(posedge ref_clk) disable iff (!rstn)
		(in_lookup && cyc_reg.write && !hold_valid_reg) |=> !host_ready_n;
	endproperty
	a_write_zero_wait: assert property (p_write_zero_wait) else $error("write not zero wait");

	property p_write_miss_no_update;
		@(posedge ref_clk) disable iff (!rstn)
		(lk_wr_go && !any_hit) |=> (way0_write_strobe_n && way1_write_strobe_n);
	endproperty
	a_write_miss_no_update: assert property (p_write_miss_no_update) else $error("miss wrote cache");

	property p_queue_bound;
		@(posedge ref_clk) disable iff (!rstn)
		(wq_count_reg <= 3'h4) && ($countones(wq_valid_reg) == int'(wq_count_reg));
	endproperty
	a_queue_bound: assert property (p_queue_bound) else $error("queue count wrong");

	property p_read_first;
		@(posedge ref_clk) disable iff (!rstn)
		(rd_want && slot_free) |=> (dram_req_valid && !dram_req.write);
	endproperty
	a_read_first: assert property (p_read_first) else $error("write passed a read");

	property p_reset_empty;
		@(posedge ref_clk)
		$rose(rstn) |-> (wq_count_reg == 3'h0) && !dram_req_valid && host_ready_n;
	endproperty
	a_reset_empty: assert property (p_reset_empty) else $error("state after reset");

endmodule : cache_and_write_buffer_ctrl
`default_nettype wire

// ==== dv/dram_seq_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module dram_seq_model
	import cache_wb_pkg::*;
(
	// Control
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	input  wire logic         stall,
	// Sequencer port
	input  wire logic         dram_req_valid,
	input  wire mem_req_t     dram_req,
	output logic              dram_req_ready,
	output logic              dram_rd_valid,
	output logic [DATA_W-1:0] dram_rd_data,
	input  wire logic         dram_rd_ready
);
	logic [ADDR_W-1:0] rq[$];
	logic [DATA_W-1:0] mem[logic [ADDR_W-1:0]];
	logic [DATA_W-1:0] w;
	function automatic logic [DATA_W-1:0] rdw(input logic [ADDR_W-1:0] a);
		return mem.exists(a) ? mem[a] : {6'h15, a};
	endfunction : rdw
	initial {dram_req_ready, dram_rd_valid, dram_rd_data} = '0;
	always @(posedge ref_clk) begin
		dram_req_ready <= rstn && !stall;
		if (!rstn) begin
			dram_rd_valid <= 1'b0;
			rq.delete();
		end else begin
			if (dram_req_valid && dram_req_ready && dram_req.write) begin
				w = rdw(dram_req.addr);
				for (int i = 0; i < BE_W; i++)
					if (dram_req.byte_en[i]) w[8*i+:8] = dram_req.data[8*i+:8];
				mem[dram_req.addr] = w;
			end else if (dram_req_valid && dram_req_ready)
				for (int i = 0; i < (dram_req.burst ? 4 : 1); i++)
					rq.push_back(dram_req.addr ^ ADDR_W'(i));
			// In-order beats, one idle cycle apart; idle data is scrambled
			if (dram_rd_valid && dram_rd_ready) begin
				dram_rd_valid <= 1'b0;
				dram_rd_data  <= ~dram_rd_data;
			end else if (!dram_rd_valid && rq.size() > 0) begin
				dram_rd_valid <= 1'b1;
				dram_rd_data  <= rdw(rq.pop_front());
			end
		end
	end
endmodule : dram_seq_model
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import cache_wb_pkg::*;
	localparam logic [ADDR_W-1:0] A = 26'h0000102;
	localparam logic [ADDR_W-1:0] QB = 26'h0300000;
	logic ref_clk, rstn, host_addr_strobe_n, host_non_cache_n, host_write, stall;
	logic cfg_noncache_region, host_ready_n, cache_low_addr1, cache_low_addr0;
	logic way0_output_enable_n, way1_output_enable_n, way0_write_strobe_n, way1_write_strobe_n;
	logic cache_addr_latch_en, dram_req_valid, dram_req_ready, dram_rd_valid, dram_rd_ready;
	logic [1:0]        cfg_cache_size;
	logic [ADDR_W-1:0] host_addr;
	logic [BE_W-1:0]   host_byte_en_n, cache_byte_select_n;
	logic [DATA_W-1:0] host_wdata, host_rdata, cache_wdata, dram_rd_data, rdat;
	mem_req_t          dram_req;
	mem_req_t          log_q[$];
	int                failures, samples_checked, wstb, lat;
	cache_and_write_buffer_ctrl uut (.*);
	dram_seq_model far_end (.*);
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (dram_req_valid && dram_req_ready) log_q.push_back(dram_req);
		if (!way0_write_strobe_n || !way1_write_strobe_n) wstb++;
	end
	function automatic logic [DATA_W-1:0] pat(input logic [ADDR_W-1:0] a);
		return {6'h15, a};
	endfunction : pat
	task check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		if (seen !== exp) failures++;
	endtask : check
	task print_verdict;
		$display("%0d values checked, %0d failures", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	task cyc(input logic w, input logic nc, input logic [ADDR_W-1:0] a,
		input logic [BE_W-1:0] ben, input logic [DATA_W-1:0] d);
		{host_addr_strobe_n, host_write, host_non_cache_n, host_addr, host_byte_en_n,
			host_wdata} <= {1'b0, w, !nc, a, ben, d};
		@(posedge ref_clk);
		host_addr_strobe_n <= 1'b1;
		for (lat = 0; host_ready_n !== 1'b0 && lat < 400; lat++)
			@(posedge ref_clk);
		if (lat == 400) failures++;
		rdat = host_rdata;
	endtask : cyc
	task rd(input logic [ADDR_W-1:0] a, input int m);
		int n;
		n = log_q.size();
		cyc(1'b0, 1'b0, a, 4'h0, '0);
		check(log_q.size() - n, m);
	endtask : rd
	task t_read;
		int offs[6] = '{32'h1000, 0, 32'h1000, 32'h2000, 32'h1000, 0};
		int miss[6] = '{1, 0, 0, 1, 0, 1};
		wstb = 0;
		rd(A, 1);
		check(wstb, 4);
		check({log_q[$].burst, log_q[$].addr, rdat}, {1'b1, A ^ 26'h3, pat(A)});
		rd(A ^ 26'h1, 0);
		check({lat <= 3, way0_output_enable_n ^ way1_output_enable_n, cache_byte_select_n,
			cache_addr_latch_en, cache_low_addr1, cache_low_addr0}, 9'h187);
		for (int i = 0; i < 6; i++) rd(A + ADDR_W'(offs[i]), miss[i]);
		cfg_noncache_region <= 1'b1;
		rd(A, 1);
		cfg_noncache_region <= 1'b0;
		check({log_q[$].burst, rdat}, {1'b0, pat(A)});
		rd(A, 1);
		cyc(1'b0, 1'b1, 26'h0000205, 4'h0, '0);
		check({log_q[$].burst, rdat}, {1'b0, pat(26'h0000205)});
		rd(26'h0000205, 1);
		$display("test read done");
	endtask : t_read
	task t_write;
		wstb = 0;
		cyc(1'b1, 1'b0, A, 4'hC, 32'h55AA_1234);
		check({lat <= 3, way0_write_strobe_n ^ way1_write_strobe_n, cache_byte_select_n,
			cache_wdata[15:0]}, {2'h3, 4'hC, 16'h1234});
		cyc(1'b1, 1'b0, 26'h0000300, 4'h0, 32'h0BAD_F00D);
		check(wstb, 1);
		repeat (10) @(posedge ref_clk);
		check({log_q[$-1].addr, log_q[$-1].byte_en}, {A, 4'h3});
		check(log_q[$].data, 32'h0BAD_F00D);
		$display("test write done");
	endtask : t_write
	task t_queue;
		int n;
		n = log_q.size();
		stall <= 1'b1;
		// First write parks in the stalled request slot, the rest stay queued
		cyc(1'b1, 1'b0, QB, 4'h0, 32'h0);
		cyc(1'b1, 1'b0, QB + 26'h1, 4'hC, 32'h0000_BEEF);
		cyc(1'b1, 1'b0, QB + 26'h1, 4'h3, 32'hF00D_0000);
		for (int k = 2; k < 6; k++) begin
			cyc(1'b1, 1'b0, QB + ADDR_W'(k), 4'h0, DATA_W'(k));
			check(lat <= 3, 1'b1);
		end
		fork
			cyc(1'b1, 1'b0, QB + 26'h6, 4'h0, 32'h6);
			begin
				repeat (40) @(posedge ref_clk);
				stall <= 1'b0;
			end
		join
		check(lat >= 40, 1'b1);
		repeat (60) @(posedge ref_clk);
		for (int k = 0; k < 7; k++) check(log_q[n + k].addr, QB + ADDR_W'(k));
		check(log_q.size() - n, 7);
		check({log_q[n + 1].byte_en, log_q[n + 1].data}, {4'hF, 32'hF00D_BEEF});
		$display("test queue done");
	endtask : t_queue
	task t_fwd;
		int n, k;
		n = log_q.size();
		k = -1;
		stall <= 1'b1;
		for (int i = 0; i < 3; i++) cyc(1'b1, 1'b0, QB + ADDR_W'(16 + i), 4'hE, 32'h5A);
		fork
			cyc(1'b0, 1'b1, QB + 26'h17, 4'h0, '0);
			begin
				repeat (10) @(posedge ref_clk);
				stall <= 1'b0;
			end
		join
		foreach (log_q[i])
			if (i >= n && !log_q[i].write && k < 0) k = i;
		check(k >= n && k <= n + 1, 1'b1);
		// Keep the byte write queued behind a stalled one while it is read back
		stall <= 1'b1;
		cyc(1'b1, 1'b0, QB + 26'h20, 4'h0, '0);
		cyc(1'b1, 1'b0, QB + 26'h21, 4'hE, 32'h5A);
		fork
			cyc(1'b0, 1'b1, QB + 26'h21, 4'h0, '0);
			begin
				repeat (10) @(posedge ref_clk);
				stall <= 1'b0;
			end
		join
		check(rdat, (pat(QB + 26'h21) & 32'hFFFF_FF00) | 32'h5A);
		$display("test forward done");
	endtask : t_fwd
	task t_size;
		rstn <= 1'b0;
		cfg_cache_size <= SIZE_128K;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		check({host_ready_n, cache_byte_select_n, dram_req_valid}, 6'h3E);
		rd(A, 1);
		rd(A + 26'h2000, 1);
		rd(A + 26'h6000, 1);
		// Three lines share one set only with the smaller sizes
		rd(A, 0);
		rd(A + 26'h2000, 0);
		rd(A + 26'h6000, 0);
		$display("test size done");
	endtask : t_size
	initial begin
		{rstn, host_addr_strobe_n, host_non_cache_n, host_write, stall} = 5'b01100;
		{cfg_noncache_region, host_addr, host_byte_en_n, host_wdata} = '0;
		{failures, samples_checked, wstb} = '0;
		cfg_cache_size = SIZE_32K;
		repeat (20) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		check({host_ready_n, cache_byte_select_n, dram_req_valid}, 6'h3E);
		t_read;
		t_write;
		t_queue;
		t_fwd;
		t_size;
		print_verdict;
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		failures++;
		print_verdict;
	end
endmodule : tb_top
`default_nettype wire
